// File: rtl/bsteer_pkg.sv
package bsteer_pkg;

  // ***************************************************************
  // bus geometry
  // ***************************************************************
  localparam int BUS_W  = 32;
  localparam int LANE_N = 4;
  localparam int BYTE_W = 8;

  // ***************************************************************
  // lane select patterns, active low
  // ***************************************************************
  localparam logic [3:0] LANE_WORD = 4'h0;
  localparam logic [3:0] LANE_B0   = 4'hE;
  localparam logic [3:0] LANE_B1   = 4'hD;
  localparam logic [3:0] LANE_B2   = 4'hB;
  localparam logic [3:0] LANE_B3   = 4'h7;
  localparam logic [3:0] LANE_NONE = 4'hF;

  // ***************************************************************
  // reset values of the link outputs
  // ***************************************************************
  localparam logic        RST_MREQ_N = 1'b1;
  localparam logic        RST_SEQ    = 1'b0;
  localparam logic        RST_WNR    = 1'b0;
  localparam logic        RST_WNB    = 1'b1;
  localparam logic [31:0] RST_WORD   = 32'h0000_0000;

  // ***************************************************************
  // timing and sizing defaults
  // ***************************************************************
  localparam int WAIT_CYCLES_DEF = 0;
  localparam int WAIT_CYCLES_MAX = 255;
  localparam int MEM_AW_DEF      = 8;

  // ***************************************************************
  // device end states
  // ***************************************************************
  typedef enum logic [0:0] {
    BSTEER_IDLE = 1'b0,
    BSTEER_DATA = 1'b1
  } bsteer_state_e;

endpackage

// File: rtl/bsteer_link_if.sv
interface bsteer_link_if;

  // ***************************************************************
  // address and control, driven by the device end
  // ***************************************************************
  logic [31:0] address;
  logic [3:0]  lane_select_n;
  logic        write_not_read;
  logic        word_not_byte;
  logic        memory_request_n;
  logic        sequential_cycle;

  // ***************************************************************
  // data, split by direction; enable drives external drivers
  // ***************************************************************
  logic [31:0] dout;
  logic        write_driver_enable_n;
  logic [31:0] din;

  // ***************************************************************
  // stretch, driven by the controller end
  // ***************************************************************
  logic        cycle_stretch_n;

  modport dev (
    output address,
    output lane_select_n,
    output write_not_read,
    output word_not_byte,
    output memory_request_n,
    output sequential_cycle,
    output dout,
    output write_driver_enable_n,
    input  din,
    input  cycle_stretch_n
  );

  modport ctl (
    input  address,
    input  lane_select_n,
    input  write_not_read,
    input  word_not_byte,
    input  memory_request_n,
    input  sequential_cycle,
    input  dout,
    input  write_driver_enable_n,
    output din,
    output cycle_stretch_n
  );

endinterface

// File: rtl/bsteer_dev.sv
// Functional notes
// - driver enable low only in write cycles
// - data bus enable low forces enable high
// - request announces the next bus cycle
// - controller samples request at unstretched boundary
// - fast capture points for controller
// - relaxed capture points at low rate
// - controller derives stretch from sampled request
// - endian select chooses byte ordering
// - little endian: byte 0 on bits 7:0
// - big endian: byte 0 on bits 31:24
// - word access: all bits, ignore address 1:0
// - byte store replicates low byte four times
// - memory writes only the addressed byte
// - little endian loads pick upward from 7:0
// - big endian loads pick downward from 31:24
// - loaded byte zero extended into low bits
// - lane selects decode address bits combinationally
// - word 0000, bytes 1110 1101 1011 0111
// - same decode in both endian modes
// - lane to data bits mapping per endianness
// - byte reads drive all lanes defined
// - memory may stretch cycles by holding low
module bsteer_dev (
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        SYS_RST,
  // configuration
  input  wire logic        BIG_END,
  input  wire logic        DATA_BUS_ENABLE,
  // request
  input  wire logic        REQ_VALID,
  output logic             REQ_READY,
  input  wire logic        REQ_WRITE,
  input  wire logic        REQ_BYTE,
  input  wire logic [31:0] REQ_ADDR,
  input  wire logic [31:0] REQ_WDATA,
  // read answer
  output logic             RSP_VALID,
  output logic [31:0]      RSP_RDATA,
  // link
  bsteer_link_if.dev       LINK
);

  // ***************************************************************
  // helper functions
  // ***************************************************************
  function automatic logic [3:0] lane_decode(input logic wnb, input logic [1:0] a);
    logic [3:0] r;
    r = bsteer_pkg::LANE_WORD;
    if (!wnb) begin
      case (a)
        2'h0:    r = bsteer_pkg::LANE_B0;
        2'h1:    r = bsteer_pkg::LANE_B1;
        2'h2:    r = bsteer_pkg::LANE_B2;
        default: r = bsteer_pkg::LANE_B3;
      endcase
    end
    return r;
  endfunction

  function automatic logic [7:0] byte_pick(input logic [31:0] d, input logic [1:0] a,
                                           input logic big);
    logic [1:0] pos;
    logic [7:0] r;
    pos = big ? ~a : a;
    case (pos)
      2'h0:    r = d[7:0];
      2'h1:    r = d[15:8];
      2'h2:    r = d[23:16];
      default: r = d[31:24];
    endcase
    return r;
  endfunction

  // ***************************************************************
  // state
  // ***************************************************************
  bsteer_pkg::bsteer_state_e state;
  logic        pend;
  logic        p_write;
  logic        p_byte;
  logic [31:0] p_addr;
  logic [31:0] p_wdata;
  logic        mreq_n;
  logic        seq;
  logic        have_prev;
  logic [31:0] bus_addr;
  logic        bus_wnr;
  logic        bus_wnb;
  logic [31:0] bus_dout;
  logic        take;
  logic        boundary;
  logic        consume;
  logic        byte_store_op;
  logic        byte_load_op;
  logic        next_seq;
  logic [29:0] next_word;

  // a bus cycle ends on an edge with stretch high
  assign boundary = LINK.cycle_stretch_n;
  // single holding slot keeps one request in flight
  assign REQ_READY = !pend;
  assign take      = REQ_VALID && !pend;
  assign consume   = boundary && !mreq_n;

  assign byte_store_op = p_write && p_byte;
  assign byte_load_op  = !bus_wnr && !bus_wnb;
  assign next_word     = bus_addr[31:2] + 30'h1;
  assign next_seq      = have_prev && (p_write == bus_wnr) && !p_byte && bus_wnb
                         && (p_addr[31:2] == next_word);

  // ***************************************************************
  // request holding slot
  // ***************************************************************
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pend    <= 1'b0;
      p_write <= 1'b0;
      p_byte  <= 1'b0;
      p_addr  <= bsteer_pkg::RST_WORD;
      p_wdata <= bsteer_pkg::RST_WORD;
    end else if (take) begin
      pend    <= 1'b1;
      p_write <= REQ_WRITE;
      p_byte  <= REQ_BYTE;
      p_addr  <= REQ_ADDR;
      p_wdata <= REQ_WDATA;
    end else if (consume) begin
      pend <= 1'b0;
    end
  end

  // ***************************************************************
  // request and sequential indications
  // ***************************************************************
  // announce one cycle ahead
  // held while stretched, so it only moves on a boundary
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      mreq_n <= bsteer_pkg::RST_MREQ_N;
      seq    <= bsteer_pkg::RST_SEQ;
    end else if (boundary) begin
      mreq_n <= !(pend && mreq_n);
      seq    <= pend && mreq_n && next_seq;
    end
  end

  // ***************************************************************
  // cycle state
  // ***************************************************************
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state <= bsteer_pkg::BSTEER_IDLE;
    end else begin
      case (state)
        bsteer_pkg::BSTEER_IDLE: begin
          if (consume) begin
            state <= bsteer_pkg::BSTEER_DATA;
          end
        end
        bsteer_pkg::BSTEER_DATA: begin
          if (boundary) begin
            state <= bsteer_pkg::BSTEER_IDLE;
          end
        end
        default: state <= bsteer_pkg::BSTEER_IDLE;
      endcase
    end
  end

  // ***************************************************************
  // address, control and write data
  // ***************************************************************
  // idle cycles keep the last address and type to save transitions
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      bus_addr  <= bsteer_pkg::RST_WORD;
      bus_wnr   <= bsteer_pkg::RST_WNR;
      bus_wnb   <= bsteer_pkg::RST_WNB;
      bus_dout  <= bsteer_pkg::RST_WORD;
      have_prev <= 1'b0;
    end else if (consume) begin
      bus_addr  <= p_addr;
      bus_wnr   <= p_write;
      bus_wnb   <= !p_byte;
      have_prev <= 1'b1;
      if (byte_store_op) begin
        bus_dout <= {4{p_wdata[7:0]}};
      end else if (p_write) begin
        bus_dout <= p_wdata;
      end
    end
  end

  // ***************************************************************
  // read answer
  // ***************************************************************
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      RSP_VALID <= 1'b0;
      RSP_RDATA <= bsteer_pkg::RST_WORD;
    end else begin
      RSP_VALID <= (state == bsteer_pkg::BSTEER_DATA) && boundary && !bus_wnr;
      if ((state == bsteer_pkg::BSTEER_DATA) && boundary && !bus_wnr) begin
        if (byte_load_op) begin
          RSP_RDATA <= {24'h00_0000, byte_pick(LINK.din, bus_addr[1:0], BIG_END)};
        end else begin
          RSP_RDATA <= LINK.din;
        end
      end
    end
  end

  // ***************************************************************
  // link outputs
  // ***************************************************************
  assign LINK.address          = bus_addr;
  assign LINK.write_not_read   = bus_wnr;
  assign LINK.word_not_byte    = bus_wnb;
  assign LINK.memory_request_n = mreq_n;
  assign LINK.sequential_cycle = seq;
  assign LINK.dout             = bus_dout;
  assign LINK.lane_select_n    = lane_decode(bus_wnb, bus_addr[1:0]);
  assign LINK.write_driver_enable_n = !((state == bsteer_pkg::BSTEER_DATA) && bus_wnr
                                        && DATA_BUS_ENABLE);

endmodule

// File: rtl/bsteer_ctl.sv
module bsteer_ctl #(
  parameter int WAIT_CYCLES = bsteer_pkg::WAIT_CYCLES_DEF,
  parameter int MEM_AW      = bsteer_pkg::MEM_AW_DEF
) (
  // clock and reset
  input  wire logic              SYS_CLK,
  input  wire logic              SYS_RST,
  // configuration
  input  wire logic              BIG_END,
  // observation
  output logic                   ACCESS_DONE,
  output logic                   ACCESS_WRITE,
  input  wire logic [MEM_AW-1:0] PEEK_INDEX,
  output logic [31:0]            PEEK_DATA,
  // link
  bsteer_link_if.ctl             LINK
);

  // ***************************************************************
  // parameter checks
  // ***************************************************************
  if (WAIT_CYCLES < 0 || WAIT_CYCLES > bsteer_pkg::WAIT_CYCLES_MAX) begin : g_bad_wait
    $error("WAIT_CYCLES out of range");
  end
  if (MEM_AW < 1 || MEM_AW > 16) begin : g_bad_aw
    $error("MEM_AW out of range");
  end

  localparam logic [7:0] WAIT_N = 8'(WAIT_CYCLES);

  logic [31:0]       mem [2**MEM_AW];
  logic              in_data;
  logic [7:0]        wcnt;
  logic              boundary;
  logic [MEM_AW-1:0] idx;

  assign idx = LINK.address[MEM_AW+1:2];

  // ***************************************************************
  // stretch and cycle tracking
  // ***************************************************************
  // stretch from sampled request, not from a cycle earlier
  assign LINK.cycle_stretch_n = !(in_data && (wcnt != WAIT_N));
  assign boundary             = LINK.cycle_stretch_n;

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      in_data <= 1'b0;
      wcnt    <= 8'h00;
    end else if (boundary) begin
      // request read only on a boundary
      in_data <= !LINK.memory_request_n;
      wcnt    <= 8'h00;
    end else begin
      wcnt <= wcnt + 8'h01;
    end
  end

  // ***************************************************************
  // storage, byte enables per lane
  // ***************************************************************
  // control and data taken at cycle end
  always_ff @(posedge SYS_CLK) begin
    if (in_data && boundary && LINK.write_not_read && !LINK.write_driver_enable_n) begin
      for (int i = 0; i < bsteer_pkg::LANE_N; i++) begin
        if (!LINK.lane_select_n[i]) begin
          if (BIG_END) begin
            mem[idx][(3 - i) * 8 +: 8] <= LINK.dout[(3 - i) * 8 +: 8];
          end else begin
            mem[idx][i * 8 +: 8] <= LINK.dout[i * 8 +: 8];
          end
        end
      end
    end
  end

  // byte 0 sits where the endianness puts it
  // whole word driven, no lane left floating
  assign LINK.din = mem[idx];

  // ***************************************************************
  // observation
  // ***************************************************************
  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ACCESS_DONE  <= 1'b0;
      ACCESS_WRITE <= 1'b0;
      PEEK_DATA    <= bsteer_pkg::RST_WORD;
    end else begin
      ACCESS_DONE  <= in_data && boundary;
      ACCESS_WRITE <= in_data && boundary && LINK.write_not_read;
      PEEK_DATA    <= mem[PEEK_INDEX];
    end
  end

endmodule

// File: verif/bsteer_assertions.sv
module bsteer_assertions #(
  parameter int WAIT_CYCLES = 0
) (
  // clock, reset and data bus enable
  input logic        SYS_CLK,
  input logic        SYS_RST,
  input logic        DATA_BUS_ENABLE,
  // link
  input logic [31:0] address,
  input logic [3:0]  lane_select_n,
  input logic        write_not_read,
  input logic        word_not_byte,
  input logic        memory_request_n,
  input logic        sequential_cycle,
  input logic [31:0] dout,
  input logic        write_driver_enable_n,
  input logic        cycle_stretch_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // length of the current stretch run
  logic [8:0] stall_cnt;

  always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      stall_cnt <= 9'h000;
    end else if (!cycle_stretch_n) begin
      stall_cnt <= stall_cnt + 9'h001;
    end else begin
      stall_cnt <= 9'h000;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  property p_lane_word;
    word_not_byte |-> lane_select_n == 4'h0;
  endproperty
  a_lane_word: assert property (p_lane_word) else $error("word lane selects wrong");

  property p_lane_byte;
    !word_not_byte |-> lane_select_n == ~(4'h1 << address[1:0]);
  endproperty
  a_lane_byte: assert property (p_lane_byte) else $error("byte lane selects wrong");

  property p_dbe_off;
    !DATA_BUS_ENABLE |-> write_driver_enable_n;
  endproperty
  a_dbe_off: assert property (p_dbe_off) else $error("driver enabled with bus disabled");

  property p_enable_write;
    !write_driver_enable_n |-> write_not_read;
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("driver enabled on read");

  property p_byte_repl;
    !write_driver_enable_n && !word_not_byte |-> dout == {4{dout[7:0]}};
  endproperty
  a_byte_repl: assert property (p_byte_repl) else $error("store byte not replicated");

  property p_request_ahead;
    $fell(write_driver_enable_n) && $past(DATA_BUS_ENABLE) |-> !$past(memory_request_n);
  endproperty
  a_request_ahead: assert property (p_request_ahead) else $error("data cycle not announced");

  property p_stretch_from_req;
    $fell(cycle_stretch_n) |-> !$past(memory_request_n);
  endproperty
  a_stretch_from_req: assert property (p_stretch_from_req) else $error("stretch without request");

  property p_stretch_len;
    $rose(cycle_stretch_n) |-> stall_cnt == WAIT_CYCLES;
  endproperty
  a_stretch_len: assert property (p_stretch_len) else $error("stretch length wrong");

  // no boundary while stretched, so the bus must not move
  property p_stretch_hold;
    !cycle_stretch_n |=> $stable(address) && $stable(dout) && $stable(memory_request_n);
  endproperty
  a_stretch_hold: assert property (p_stretch_hold) else $error("bus moved while stretched");

  // sequential flag only ever rides on an announced request
  property p_seq_req;
    sequential_cycle |-> !memory_request_n;
  endproperty
  a_seq_req: assert property (p_seq_req) else $error("sequential without request");

endmodule

// File: verif/byte_lane_bus_steering_bench.sv
module byte_lane_bus_steering_bench;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int WAIT = 2;

  logic        SYS_CLK = 1'b0;
  logic        SYS_RST = 1'b1;
  logic        big = 1'b0;
  logic        dbe = 1'b1;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic        req_byte = 1'b0;
  logic [31:0] req_addr = 32'h0000_0000;
  logic [31:0] req_wdata = 32'h0000_0000;
  logic        req_ready;
  logic        rsp_valid;
  logic [31:0] rsp_rdata;
  logic [31:0] mem_m [4];
  logic [31:0] exp_q [$];
  logic [31:0] n;
  logic [3:0]  peek_idx = 4'h0;
  logic [31:0] peek_data;
  logic        access_done;
  logic        access_write;
  int          seq_cnt = 0;
  int          fails = 0;
  int          compares = 0;
  int          cyc = 0;

  bsteer_link_if link ();

  bsteer_dev bsteer_dev_i (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST), .BIG_END(big), .DATA_BUS_ENABLE(dbe),
    .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_WRITE(req_write), .REQ_BYTE(req_byte),
    .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .RSP_VALID(rsp_valid), .RSP_RDATA(rsp_rdata), .LINK(link));

  bsteer_ctl #(.WAIT_CYCLES(WAIT), .MEM_AW(4)) bsteer_ctl_i (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .BIG_END(big), .ACCESS_DONE(access_done), .ACCESS_WRITE(access_write), .PEEK_INDEX(peek_idx),
    .PEEK_DATA(peek_data), .LINK(link));

  bsteer_assertions #(.WAIT_CYCLES(WAIT)) bsteer_assertions_i (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .DATA_BUS_ENABLE(dbe), .address(link.address), .lane_select_n(link.lane_select_n),
    .write_not_read(link.write_not_read), .word_not_byte(link.word_not_byte),
    .memory_request_n(link.memory_request_n), .sequential_cycle(link.sequential_cycle), .dout(link.dout),
    .write_driver_enable_n(link.write_driver_enable_n), .cycle_stretch_n(link.cycle_stretch_n));

  always #2 SYS_CLK = ~SYS_CLK;

  task automatic wrap_up;
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // held from a falling edge until the rising edge that takes it
  task automatic req(input logic w, input logic b, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    @(negedge SYS_CLK);
    req_valid = 1'b1;
    req_write = w;
    req_byte = b;
    req_addr = a;
    req_wdata = d;
    while (req_ready !== 1'b1) @(negedge SYS_CLK);
    if (!w) exp_q.push_back(e);
    @(posedge SYS_CLK);
  endtask

  task automatic idle;
    @(negedge SYS_CLK);
    req_valid = 1'b0;
    for (int i = 0; i < 60 && exp_q.size() != 0; i++) @(negedge SYS_CLK);
    repeat (8) @(negedge SYS_CLK);
  endtask

  // word writes then every byte offset read back, plus an unaligned word read
  task automatic t_load(input logic be);
    int lane;
    int s0;
    @(negedge SYS_CLK);
    big = be;
    s0 = seq_cnt;
    for (int i = 0; i < 4; i++) begin
      mem_m[i] = $urandom;
      req(1'b1, 1'b0, 32'(i * 4), mem_m[i], 32'h0);
    end
    for (int i = 0; i < 16; i++) begin
      lane = be ? 3 - i % 4 : i % 4;
      req(1'b0, 1'b1, 32'(i), 32'h0, {24'h0, mem_m[i / 4][8 * lane +: 8]});
    end
    req(1'b0, 1'b0, 32'h7, 32'h0, mem_m[1]);
    idle();
    // only the last three of the four word writes follow on by plus four
    check(32'(seq_cnt - s0), 32'h3);
    $display("test load big=%0d done", be);
  endtask

  // byte stores land only in the lane that the endian mapping names
  task automatic t_store(input logic be);
    int lane;
    logic [31:0] d;
    @(negedge SYS_CLK);
    big = be;
    for (int off = 0; off < 4; off++) begin
      d = $urandom;
      lane = be ? 3 - off : off;
      mem_m[0][8 * lane +: 8] = d[7:0];
      req(1'b1, 1'b1, 32'(off), d, 32'h0);
    end
    req(1'b0, 1'b0, 32'h0, 32'h0, mem_m[0]);
    idle();
    $display("test store big=%0d done", be);
  endtask

  // cycles with the write driver enabled around one word write
  task automatic t_drv(input logic en, output logic [31:0] cnt);
    logic [31:0] d;
    int          dn;
    int          wr;
    @(negedge SYS_CLK);
    dbe = en;
    cnt = 32'h0;
    dn = 0;
    wr = 0;
    d = $urandom;
    req(1'b1, 1'b0, 32'h8, d, 32'h0);
    @(negedge SYS_CLK);
    req_valid = 1'b0;
    peek_idx = 4'h2;
    repeat (10) begin
      @(negedge SYS_CLK);
      if (link.write_driver_enable_n === 1'b0) cnt++;
      if (access_done === 1'b1) dn++;
      if (access_write === 1'b1) wr++;
    end
    // a disabled bus must leave the stored word untouched
    if (en) mem_m[2] = d;
    check(peek_data, mem_m[2]);
    check(32'(dn), 32'h1);
    check(32'(wr), 32'h1);
    dbe = 1'b1;
    $display("test driver dbe=%0d done", en);
  endtask

  always @(negedge SYS_CLK) begin
    if (rsp_valid === 1'b1) begin
      check(rsp_rdata, exp_q.size() != 0 ? exp_q.pop_front() : 32'hX);
    end
  end

  // sequential announcements seen on the link
  always @(negedge SYS_CLK) begin
    if (link.sequential_cycle === 1'b1) seq_cnt++;
  end

  // far above the few hundred cycles the tests need
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    void'($urandom(32'h7D85BB88));
    repeat (5) @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    SYS_RST = 1'b0;
    t_load(1'b0);
    t_load(1'b1);
    t_store(1'b0);
    t_store(1'b1);
    t_drv(1'b1, n);
    check(n, 32'(1 + WAIT));
    t_drv(1'b0, n);
    check(n, 32'h0);
    check(32'(exp_q.size()), 32'h0);
    wrap_up();
  end

endmodule
